// ---- cdsr_channel.v ----
// multiplex/selector device service request sequence with register slave
//
// Implementation choices: the AXI4-Lite slave port and the address map.
`timescale 1ns/1ps
`include "cdsr_defs.vh"

// Overview of operation
// - request in starts select sequence
// - multiplex repeats full sequence per byte
// - selector idle status: stack, interrupt request
// - interrupt response stores status word
// - tie-break: never interrupt processor operation
// - address in latches address, starts clock
// - phase one reset, phase two parity
// - good parity raises command out phase three
// - address in fall ends command out
// - multiplex: service in requests data priority
// - word zero op, word one data
// - service out answers, command out fails
// - status in clock, parity check
// - multiplex: good status requests examination priority
// - examine queue full and chaining
// - queue full: stack, set stack bit
// - else form status word, interrupt
module cdsr_channel (
  input wire sys_clk,
  input wire arst_n,
  input wire [7:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [7:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  input wire requestIn,
  input wire operationalIn,
  input wire addressIn,
  input wire serviceIn,
  input wire statusIn,
  input wire [7:0] busIn,
  input wire busInParity,
  output reg selectOut,
  output reg commandOut,
  output reg serviceOut,
  output reg suppressOut,
  output reg [7:0] busOut,
  input wire cpuBusy,
  output reg priorityReq,
  input wire priorityGrant,
  output reg interruptRequest,
  input wire interruptResponse
);

  // ----------------------------------------------------------------
  // states
  // ----------------------------------------------------------------
  localparam [3:0] S_IDLE = 4'h0, S_SEL = 4'h1, S_PH1 = 4'h2,
    S_PH2 = 4'h3, S_PH3 = 4'h4, S_CMDW = 4'h5, S_TAG = 4'h6,
    S_DATA = 4'h7, S_SVCW = 4'h8, S_ST2 = 4'h9, S_ST3 = 4'hA,
    S_EXAM = 4'hB, S_STACK = 4'hC;

  reg [3:0] state_q;
  reg [2:0] ctrl_q;
  reg [6:0] stat_q;
  reg [7:0] uar_q;
  reg [16:0] ucw0_q;
  reg [7:0] ucw1_q;
  reg ucw2_q;
  reg [15:0] csw_q;
  reg [7:0] sts_q;
  reg wrHit;
  reg rdHit;
  reg [31:0] rdData;

  wire parOk = ^{busIn, busInParity}; // odd parity
  wire selMode = ctrl_q[`CDSR_CTRL_SEL];
  wire wrGo = s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid &&
    !s_axi_awready;
  wire wrLo = wrGo && s_axi_wstrb[0];
  wire rdGo = s_axi_arvalid && !s_axi_rvalid && !s_axi_arready;

  // ----------------------------------------------------------------
  // address decode
  // ----------------------------------------------------------------
  // write decode
  always @* begin
    case (s_axi_awaddr)
      `CDSR_ADDR_CTRL, `CDSR_ADDR_STAT, `CDSR_ADDR_UCW0,
      `CDSR_ADDR_UCW1, `CDSR_ADDR_UCW2: wrHit = 1'b1;
      default: wrHit = 1'b0;
    endcase
  end

  // read decode and mux
  always @* begin
    rdHit = 1'b1;
    case (s_axi_araddr)
      `CDSR_ADDR_CTRL: rdData = {29'h0, ctrl_q};
      `CDSR_ADDR_STAT: rdData = {21'h0, state_q, stat_q};
      `CDSR_ADDR_UAR: rdData = {24'h0, uar_q};
      `CDSR_ADDR_UCW0: rdData = {15'h0, ucw0_q};
      `CDSR_ADDR_UCW1: rdData = {24'h0, ucw1_q};
      `CDSR_ADDR_UCW2: rdData = {31'h0, ucw2_q};
      `CDSR_ADDR_CSW: rdData = {16'h0, csw_q};
      default: begin
        rdData = 32'h0;
        rdHit = 1'b0;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // register bus handshake
  // ----------------------------------------------------------------
  // write and read channels, one transfer each at a time
  always @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `CDSR_RESP_OKAY;
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rresp <= `CDSR_RESP_OKAY;
      s_axi_rdata <= 32'h0;
    end else begin
      s_axi_awready <= wrGo;
      s_axi_wready <= wrGo;
      if (s_axi_awready) begin // answer follows the handshake
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wrHit ? `CDSR_RESP_OKAY : `CDSR_RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
      s_axi_arready <= rdGo;
      if (s_axi_arready) begin // data follows the handshake
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rdData;
        s_axi_rresp <= rdHit ? `CDSR_RESP_OKAY : `CDSR_RESP_SLVERR;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // service request sequencer
  // ----------------------------------------------------------------
  // interface tags, unit words and status flags; hardware sets win
  always @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      state_q <= S_IDLE;
      ctrl_q <= `CDSR_CTRL_RST;
      stat_q <= 7'h0;
      uar_q <= 8'h0;
      ucw0_q <= `CDSR_UCW0_RST;
      ucw1_q <= 8'h0;
      ucw2_q <= 1'b0;
      csw_q <= 16'h0;
      sts_q <= 8'h0;
      selectOut <= 1'b0;
      commandOut <= 1'b0;
      serviceOut <= 1'b0;
      suppressOut <= 1'b0;
      busOut <= 8'h0;
      priorityReq <= 1'b0;
      interruptRequest <= 1'b0;
    end else begin
      // software writes first, sequencer updates below override
      if (wrGo && wrLo && wrHit) begin
        case (s_axi_awaddr)
          `CDSR_ADDR_CTRL: ctrl_q <= s_axi_wdata[2:0];
          `CDSR_ADDR_STAT: stat_q[5:0] <= stat_q[5:0] &
            ~s_axi_wdata[5:0];
          `CDSR_ADDR_UCW0: ucw0_q <= s_axi_wdata[16:0];
          `CDSR_ADDR_UCW1: ucw1_q <= s_axi_wdata[7:0];
          `CDSR_ADDR_UCW2: ucw2_q <= s_axi_wdata[0];
          default: ;
        endcase
      end
      // answer to interrupt request stores the status word
      if (interruptRequest && interruptResponse) begin
        interruptRequest <= 1'b0;
        stat_q[`CDSR_STAT_INTPEND] <= 1'b0;
        stat_q[`CDSR_STAT_STORED] <= 1'b1;
      end
      case (state_q)
        S_IDLE: begin
          suppressOut <= 1'b0;
          // tie-break: processor work keeps priority
          if (requestIn && !cpuBusy && !interruptRequest) begin
            selectOut <= 1'b1;
            state_q <= S_SEL;
          end
        end
        S_SEL: begin
          // unit answers with operational and address
          if (addressIn && operationalIn) begin
            uar_q <= busIn;
            selectOut <= 1'b0;
            state_q <= S_PH1;
          end
        end
        S_PH1: begin
          // phase one clears leftovers of the last byte
          serviceOut <= 1'b0;
          commandOut <= 1'b0;
          state_q <= S_PH2;
        end
        S_PH2: begin
          if (!parOk) begin
            stat_q[`CDSR_STAT_ADRCHK] <= 1'b1;
            stat_q[`CDSR_STAT_ICC] <= 1'b1;
            stat_q[`CDSR_STAT_LOGOUT] <= 1'b1;
            state_q <= S_IDLE;
          end else begin
            state_q <= S_PH3;
          end
        end
        S_PH3: begin
          commandOut <= 1'b1;
          state_q <= S_CMDW;
        end
        S_CMDW: begin
          // fall of address in stops the clock, command out drops
          if (!addressIn) begin
            commandOut <= 1'b0;
            state_q <= S_TAG;
          end
        end
        S_TAG: begin
          if (!operationalIn) begin
            state_q <= S_IDLE;
          end else if (statusIn) begin
            sts_q <= busIn;
            state_q <= S_ST2;
          end else if (serviceIn && !selMode) begin
            priorityReq <= 1'b1;
            state_q <= S_DATA;
          end
        end
        S_DATA: begin
          if (priorityGrant) begin
            priorityReq <= 1'b0;
            if (ucw0_q[15:0] == 16'h0) begin
              commandOut <= 1'b1;
            end else begin
              serviceOut <= 1'b1;
              ucw0_q[15:0] <= ucw0_q[15:0] - 16'h1;
              if (ucw0_q[`CDSR_UCW0_WRITE]) begin
                busOut <= ucw1_q;
              end else begin
                ucw1_q <= busIn;
              end
            end
            state_q <= S_SVCW;
          end
        end
        S_SVCW: begin
          // hold the answer until the unit drops its tag
          if (!serviceIn && !statusIn) begin
            serviceOut <= 1'b0;
            commandOut <= 1'b0;
            state_q <= S_IDLE;
          end
        end
        S_ST2: begin
          if (!parOk) begin
            stat_q[`CDSR_STAT_STSCHK] <= 1'b1;
            stat_q[`CDSR_STAT_ICC] <= 1'b1;
            stat_q[`CDSR_STAT_LOGOUT] <= 1'b1;
            state_q <= S_IDLE;
          end else begin
            state_q <= S_ST3;
          end
        end
        S_ST3: begin
          if (selMode) begin
            // idle selector: secondary status stacked
            commandOut <= 1'b1;
            suppressOut <= 1'b1;
            csw_q <= {uar_q, sts_q};
            interruptRequest <= 1'b1;
            stat_q[`CDSR_STAT_INTPEND] <= 1'b1;
            state_q <= S_STACK;
          end else begin
            priorityReq <= 1'b1;
            state_q <= S_EXAM;
          end
        end
        S_EXAM: begin
          if (priorityGrant) begin
            priorityReq <= 1'b0;
            if (ctrl_q[`CDSR_CTRL_CHAIN] &&
                (sts_q & `CDSR_DEV_END) != 8'h0) begin
              stat_q[`CDSR_STAT_CHAINED] <= 1'b1;
              serviceOut <= 1'b1;
              state_q <= S_SVCW;
            end else if (ctrl_q[`CDSR_CTRL_QFULL] ||
                interruptRequest) begin
              commandOut <= 1'b1;
              ucw2_q <= 1'b1;
              state_q <= S_SVCW;
            end else begin
              csw_q <= {uar_q, sts_q};
              interruptRequest <= 1'b1;
              stat_q[`CDSR_STAT_INTPEND] <= 1'b1;
              serviceOut <= 1'b1;
              state_q <= S_SVCW;
            end
          end
        end
        S_STACK: begin
          if (!statusIn) begin
            commandOut <= 1'b0;
            state_q <= S_IDLE;
          end
        end
        default: state_q <= S_IDLE;
      endcase
    end
  end

endmodule // cdsr_channel

// ---- cdsr_channel_chk.sv ----
// assertions on the channel service request ports
`timescale 1ns/1ps
module cdsr_channel_chk (
  input wire logic sys_clk,
  input wire logic arst_n,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic requestIn,
  input wire logic operationalIn,
  input wire logic addressIn,
  input wire logic [7:0] busIn,
  input wire logic busInParity,
  input wire logic selectOut,
  input wire logic commandOut,
  input wire logic serviceOut,
  input wire logic priorityReq,
  input wire logic priorityGrant,
  input wire logic interruptRequest,
  input wire logic interruptResponse
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!arst_n);
  // link sequence checks
  a_sel_cause: assert property (
    $rose(selectOut) |-> $past(requestIn))
    else $error("select without request");
  a_sel_drop: assert property (
    selectOut && addressIn && operationalIn |=> !selectOut)
    else $error("select held past address");
  a_cmd_good: assert property (
    $rose(addressIn) && selectOut && ^{busIn, busInParity}
    |-> ##[1:5] commandOut) else $error("no command after good address");
  a_cmd_bad: assert property (
    $rose(addressIn) && selectOut && !(^{busIn, busInParity})
    |-> ##1 !commandOut [*5]) else $error("command after bad address");
  a_cmd_end: assert property (
    $fell(addressIn) && commandOut |=> !commandOut)
    else $error("command held");
  a_req_hold: assert property (
    priorityReq && !priorityGrant |=> priorityReq) else $error("request lost");
  a_svc_grant: assert property (
    $rose(serviceOut) |-> $past(priorityGrant) || $past(priorityGrant, 2))
    else $error("service without grant");
  a_irq_clear: assert property (
    interruptRequest && interruptResponse |=> !interruptRequest)
    else $error("interrupt not cleared");
  // register bus checks
  a_wr_answer: assert property (
    s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid && !s_axi_awready
    |=> s_axi_awready && s_axi_wready ##1 s_axi_bvalid)
    else $error("late write");
  a_b_hold: assert property (
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid) else $error("bvalid lost");
  c_svc: cover property ($rose(serviceOut));
  c_irq: cover property ($rose(interruptRequest));
  c_cmd: cover property ($fell(commandOut) && !addressIn);
endmodule // cdsr_channel_chk

bind cdsr_channel cdsr_channel_chk u_chk (.sys_clk(sys_clk), .arst_n(arst_n),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .requestIn(requestIn), .operationalIn(operationalIn), .addressIn(addressIn),
  .busIn(busIn), .busInParity(busInParity), .selectOut(selectOut),
  .commandOut(commandOut), .serviceOut(serviceOut), .priorityReq(priorityReq),
  .priorityGrant(priorityGrant), .interruptRequest(interruptRequest),
  .interruptResponse(interruptResponse));

// ---- cdsr_channel_tb.sv ----
// self-checking testbench for the channel service request block
`timescale 1ns/1ps
`include "cdsr_defs.vh"
module cdsr_channel_tb;
  logic sys_clk, arst_n, awValid, awReady, wValid, wReady, bValid, bReady;
  logic arValid, arReady, rValid, rReady, reqIn, opIn, adrIn, svcIn, stsIn;
  logic par, selOut, cmdOut, svcOut, supOut, cpuBusy, prioReq, prioGrant;
  logic irq, irqResp, sawSup = 1'b0;
  logic [7:0] awAddr, arAddr, busIn, busOut;
  logic [31:0] wData, rData, v;
  logic [1:0] bResp, rResp, r;
  integer nFail = 0, checked = 0;
  cdsr_channel u_cdsr_channel (.sys_clk(sys_clk), .arst_n(arst_n),
    .s_axi_awaddr(awAddr), .s_axi_awvalid(awValid), .s_axi_awready(awReady),
    .s_axi_wdata(wData), .s_axi_wstrb(4'hF), .s_axi_wvalid(wValid),
    .s_axi_wready(wReady), .s_axi_bresp(bResp), .s_axi_bvalid(bValid),
    .s_axi_bready(bReady), .s_axi_araddr(arAddr), .s_axi_arvalid(arValid),
    .s_axi_arready(arReady), .s_axi_rdata(rData), .s_axi_rresp(rResp),
    .s_axi_rvalid(rValid), .s_axi_rready(rReady), .requestIn(reqIn),
    .operationalIn(opIn), .addressIn(adrIn), .serviceIn(svcIn),
    .statusIn(stsIn), .busIn(busIn), .busInParity(par), .selectOut(selOut),
    .commandOut(cmdOut), .serviceOut(svcOut), .suppressOut(supOut),
    .busOut(busOut), .cpuBusy(cpuBusy), .priorityReq(prioReq),
    .priorityGrant(prioGrant), .interruptRequest(irq),
    .interruptResponse(irqResp));
  cdsr_unit_model u_cdsr_unit_model (.sys_clk(sys_clk), .selectOut(selOut),
    .commandOut(cmdOut), .serviceOut(svcOut), .busOut(busOut),
    .requestIn(reqIn), .operationalIn(opIn), .addressIn(adrIn),
    .serviceIn(svcIn), .statusIn(stsIn), .busIn(busIn), .busInParity(par));
  // clock and one-cycle-late grant
  initial begin
    sys_clk = 0;
    forever #2.5 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) prioGrant <= prioReq && !prioGrant;
  // remember any suppress out pulse
  always @(posedge sys_clk) if (supOut) sawSup <= 1'b1;
  task chk(input string nm, input [31:0] exp, input [31:0] got);
    checked++;
    if (got !== exp) begin
      nFail++;
      $display("wrong value %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task results;
    $display("checks %0d mismatches %0d", checked, nFail);
    if (nFail == 0 && checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // register bus master tasks
  task wr(input [7:0] a, input [31:0] d);
    integer i;
    @(posedge sys_clk);
    {awAddr, wData, awValid, wValid, bReady} <= {a, d, 3'h7};
    for (i = 0; i < 50; i++) begin
      @(posedge sys_clk);
      if (awReady) awValid <= 1'b0;
      if (wReady) wValid <= 1'b0;
      if (bValid) break;
    end
    bReady <= 1'b0;
    if (i == 50) begin nFail++; results; end
  endtask
  task rd(input [7:0] a);
    integer i;
    @(posedge sys_clk);
    {arAddr, arValid, rReady} <= {a, 2'h3};
    for (i = 0; i < 50; i++) begin
      @(posedge sys_clk);
      if (arReady) arValid <= 1'b0;
      if (rValid) break;
    end
    {v, r} = {rData, rResp};
    rReady <= 1'b0;
    if (i == 50) begin nFail++; results; end
  endtask
  task rchk(input string nm, input [7:0] a, input [31:0] m, input [31:0] e);
    rd(a);
    chk(nm, e, v & m);
  endtask
  task irqAck;
    integer i;
    @(posedge sys_clk);
    irqResp <= 1'b1;
    for (i = 0; i < 20 && irq; i++) @(posedge sys_clk);
    irqResp <= 1'b0;
    chk("irq drop", 0, irq);
  endtask
  // watchdog
  initial begin
    repeat (60000) @(posedge sys_clk);
    nFail++;
    results;
  end
  // main sequence
  initial begin
    {arst_n, awValid, wValid, bReady, arValid, rReady, cpuBusy} = 7'h00;
    {irqResp, awAddr, arAddr, wData} = 0;
    repeat (2) @(posedge sys_clk);
    arst_n <= 1'b1;
    rchk("ctrl reset", `CDSR_ADDR_CTRL, 32'h7, 32'h0);
    rd(8'h1C);
    chk("unmapped resp", `CDSR_RESP_SLVERR, r);
    chk("unmapped data", 0, v);
    $display("registers done");
    wr(`CDSR_ADDR_UCW0, 32'h0001_0002);
    wr(`CDSR_ADDR_UCW1, 32'hA5);
    u_cdsr_unit_model.xfer(8'h3C, 8'h00, 0, 0);
    chk("write byte", 32'hA5, u_cdsr_unit_model.lastOut);
    chk("data answer", 0, u_cdsr_unit_model.lastCmd);
    rchk("uar", `CDSR_ADDR_UAR, 32'hFF, 32'h3C);
    rchk("count", `CDSR_ADDR_UCW0, 32'h1FFFF, 32'h10001);
    wr(`CDSR_ADDR_UCW0, 32'h1);
    u_cdsr_unit_model.xfer(8'h3D, 8'h5A, 0, 0);
    rchk("read byte", `CDSR_ADDR_UCW1, 32'hFF, 32'h5A);
    cpuBusy <= 1'b1;
    fork
      u_cdsr_unit_model.xfer(8'h3D, 8'h11, 0, 0);
      begin
        repeat (20) @(posedge sys_clk);
        chk("busy blocks", 0, selOut);
        cpuBusy <= 1'b0;
      end
    join
    chk("count out", 1, u_cdsr_unit_model.lastCmd);
    $display("data done");
    u_cdsr_unit_model.xfer(8'h21, 8'h0C, 1, 0);
    chk("irq", 1, irq);
    rchk("csw", `CDSR_ADDR_CSW, 32'hFFFF, 32'h210C);
    irqAck;
    rchk("stored", `CDSR_ADDR_STAT, 32'h20, 32'h20);
    wr(`CDSR_ADDR_CTRL, 32'h2);
    u_cdsr_unit_model.xfer(8'h22, 8'h0C, 1, 0);
    chk("stack", 1, u_cdsr_unit_model.lastCmd);
    rchk("stack bit", `CDSR_ADDR_UCW2, 32'h1, 32'h1);
    wr(`CDSR_ADDR_CTRL, 32'h4);
    u_cdsr_unit_model.xfer(8'h23, 8'h04, 1, 0);
    chk("chain answer", 0, u_cdsr_unit_model.lastCmd);
    chk("chain no irq", 0, irq);
    rchk("chained", `CDSR_ADDR_STAT, 32'h10, 32'h10);
    u_cdsr_unit_model.xfer(8'h24, 8'h00, 0, 1);
    rchk("adr check", `CDSR_ADDR_STAT, 32'hD, 32'hD);
    wr(`CDSR_ADDR_STAT, 32'h3F);
    rchk("stat clear", `CDSR_ADDR_STAT, 32'h3F, 32'h0);
    u_cdsr_unit_model.stsBad = 1'b1;
    u_cdsr_unit_model.xfer(8'h26, 8'h04, 1, 0);
    u_cdsr_unit_model.stsBad = 1'b0;
    chk("sts no answer", 0, u_cdsr_unit_model.lastCmd);
    rchk("sts check", `CDSR_ADDR_STAT, 32'h1F, 32'hE);
    $display("status done");
    chk("no suppress", 0, sawSup);
    wr(`CDSR_ADDR_CTRL, 32'h1);
    u_cdsr_unit_model.xfer(8'h25, 8'h0C, 1, 0);
    chk("sel stack", 1, u_cdsr_unit_model.lastCmd);
    chk("sel irq", 1, irq);
    chk("sel suppress", 1, sawSup);
    irqAck;
    chk("unit waits", 0, u_cdsr_unit_model.tmo);
    $display("selector done");
    results;
  end
endmodule // cdsr_channel_tb

// ---- cdsr_defs.vh ----
// constants for the channel device service request block
`ifndef CDSR_DEFS_VH
`define CDSR_DEFS_VH
// ----------------------------------------------------------------
// register byte addresses
// ----------------------------------------------------------------
`define CDSR_ADDR_CTRL 8'h00
`define CDSR_ADDR_STAT 8'h04
`define CDSR_ADDR_UAR 8'h08
`define CDSR_ADDR_UCW0 8'h0C
`define CDSR_ADDR_UCW1 8'h10
`define CDSR_ADDR_UCW2 8'h14
`define CDSR_ADDR_CSW 8'h18
// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define CDSR_CTRL_SEL 0
`define CDSR_CTRL_QFULL 1
`define CDSR_CTRL_CHAIN 2
`define CDSR_STAT_ADRCHK 0
`define CDSR_STAT_STSCHK 1
`define CDSR_STAT_ICC 2
`define CDSR_STAT_LOGOUT 3
`define CDSR_STAT_CHAINED 4
`define CDSR_STAT_STORED 5
`define CDSR_STAT_INTPEND 6
`define CDSR_UCW0_WRITE 16
`define CDSR_DEV_END 8'h04
// ----------------------------------------------------------------
// reset values and bus answers
// ----------------------------------------------------------------
`define CDSR_CTRL_RST 3'h0
`define CDSR_UCW0_RST 17'h00000
`define CDSR_RESP_OKAY 2'h0
`define CDSR_RESP_SLVERR 2'h2
`endif

// ---- cdsr_unit_model.sv ----
// behavioural control unit on the far side of the channel
`timescale 1ns/1ps
module cdsr_unit_model (
  input wire logic sys_clk,
  input wire logic selectOut,
  input wire logic commandOut,
  input wire logic serviceOut,
  input wire logic [7:0] busOut,
  output logic requestIn,
  output logic operationalIn,
  output logic addressIn,
  output logic serviceIn,
  output logic statusIn,
  output logic [7:0] busIn,
  output logic busInParity
);
  logic [7:0] lastOut;
  logic lastCmd;
  logic stsBad;
  integer tmo;
  logic [4:0] cond;
  // conditions the unit waits on
  assign cond = {!serviceOut && !commandOut, serviceOut || commandOut,
    !commandOut, commandOut, selectOut};
  initial begin
    {requestIn, operationalIn, addressIn, serviceIn, statusIn} = 5'h00;
    busIn = 8'h00;
    busInParity = 1'b1;
    tmo = 0;
    stsBad = 1'b0;
  end
  // bounded wait on one condition
  task wt(input integer k);
    integer i;
    for (i = 0; i < 300 && !cond[k]; i++) @(posedge sys_clk);
    if (!cond[k]) tmo++;
  endtask
  // one byte or status presentation, released lines show inverse
  task xfer(input [7:0] adr, input [7:0] byt, input isSts, input badPar);
    @(posedge sys_clk);
    requestIn <= 1'b1;
    wt(0);
    operationalIn <= 1'b1;
    addressIn <= 1'b1;
    requestIn <= 1'b0;
    busIn <= adr;
    busInParity <= ~^adr ^ badPar;
    if (badPar) repeat (8) @(posedge sys_clk);
    else wt(1);
    addressIn <= 1'b0;
    busIn <= ~adr;
    busInParity <= ^adr;
    if (!badPar) begin
      wt(2);
      if (isSts) statusIn <= 1'b1;
      else serviceIn <= 1'b1;
      busIn <= byt;
      busInParity <= ~^byt ^ stsBad;
      if (stsBad) repeat (8) @(posedge sys_clk);
      else wt(3);
      lastOut = busOut;
      lastCmd = commandOut;
      {serviceIn, statusIn} <= 2'h0;
      busIn <= ~byt;
      busInParity <= ^byt;
      wt(4);
    end
    operationalIn <= 1'b0;
  endtask
endmodule // cdsr_unit_model
